//--- pkg/tnm_pkg.sv
// Package for the command interpreter: command codes, field positions, reset values.
// Assumes a single core clock domain and an 8-bit command byte from the host.
package tnm_pkg;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RX_TEST = 8'hB0;
  localparam logic [7:0] CMD_HOST_IF_TEST = 8'hBC;
  localparam logic [7:0] CMD_FDX_LOOP_TEST = 8'hB8;
  localparam logic [7:0] CMD_TX_TEST_A = 8'hB4;
  localparam logic [7:0] CMD_TX_TEST_B = 8'hB6;
  localparam logic [7:0] CMD_INT_CLEAR = 8'h88;
  localparam logic [7:0] CMD_RESP_READY = 8'hC5;
  localparam logic [7:0] CMD_END_PHYS = 8'hA8;
  localparam logic [7:0] CMD_OFFLINE = 8'h01;
  localparam logic [4:0] PHYS_UPPER = 5'h14;
  localparam logic [7:0] RESP_PTR_OFFSET = 8'h88;
  // ----------------------------------------------------------------
  // Semaphore values
  // ----------------------------------------------------------------
  localparam logic [7:0] SEM_DONE = 8'hFF;
  localparam logic [7:0] SEM_ILLEGAL = 8'hFE;
  localparam logic [7:0] SEM_BUSY = 8'h00;
  // ----------------------------------------------------------------
  // Field positions, adjustments and reset values
  // ----------------------------------------------------------------
  localparam int PT_LEN_LSB = 11;
  localparam int PT_PRE_LSB = 8;
  localparam int PHYS_DATA_BIT = 2;
  localparam int RES_ACK_BIT = 2;
  localparam int RES_NACK_BIT = 1;
  localparam int RES_CONF_BIT = 0;
  localparam int IST0_CMD_COMPLETE_BIT = 0;
  localparam logic [5:0] FRAME_LEN_ADJ = 6'h02;
  localparam logic [3:0] PRE_CNT_ADJ = 4'h1;
  localparam logic [15:0] PATTERN_RESET = 16'h0000;
  localparam logic [15:0] SMD_DATA_RESET = 16'hFFFF;
  localparam logic [4:0] SMD_BITS = 5'h10;
  typedef enum logic [2:0] {TNM_TEST_NONE, TNM_TEST_HOST, TNM_TEST_FDX, TNM_TEST_TX, TNM_TEST_RX} tnm_test_e;
endpackage : tnm_pkg

//--- hw/tnm_cmd_interp.sv
// Command interpreter for self-test, notify and modem station-management commands.
// Assumes the host presents a command byte with a one-cycle strobe; the modem
// symbol lines are synchronous to core_clk.
`timescale 1ns/1ps
module tnm_cmd_interp #(
  parameter int STAT_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire logic [7:0] command_register,
  input wire logic [15:0] cmd_param_word0,
  input wire logic [15:0] cmd_param_word1,
  input wire logic pattern_timing_wr,
  input wire logic [15:0] pattern_timing_wdata,
  input wire logic predefined_resp_mode,
  input wire logic [STAT_W-1:0] status_set0,
  input wire logic [STAT_W-1:0] status_set1,
  input wire logic [STAT_W-1:0] status_mask0,
  input wire logic [STAT_W-1:0] status_mask1,
  input wire logic rx_frame_done,
  input wire logic [15:0] rx_frame_status,
  input wire logic station_mgmt_indication_n,
  input wire logic rx_symbol_line_0,
  input wire logic rx_symbol_line_1,
  input wire logic rx_symbol_line_2,
  output logic [7:0] semaphore_q,
  output logic [15:0] pattern_timing_word,
  output logic [5:0] rx_test_frame_len_q,
  output logic [3:0] rx_test_preamble_cnt_q,
  output logic [7:0] rx_test_preamble_octet_q,
  output logic [2:0] test_mode_q,
  output logic [STAT_W-1:0] int_status0_q,
  output logic [STAT_W-1:0] int_status1_q,
  output logic irq_n_q,
  output logic [7:0] cmd_result_word,
  output logic [15:0] cmd_return_word_q,
  output logic fd_status_we_q,
  output logic [15:0] fd_status_q,
  output logic resp_ptr_valid_q,
  output logic station_mgmt_request_n,
  output logic tx_symbol_line_0,
  output logic tx_symbol_line_1,
  output logic tx_symbol_line_2
);
  import tnm_pkg::*;

  initial begin
    if (STAT_W < 1 || STAT_W > 16) $error("STAT_W must be 1..16");
  end

  typedef enum logic [2:0] {TNM_IDLE, TNM_CLR_EXEC, TNM_SM_WAIT_ACK, TNM_SM_SHIFT_OUT, TNM_SM_WAIT_START,
    TNM_SM_SHIFT_IN, TNM_SM_WAIT_IDLE, TNM_SM_WAIT_END} tnm_state_e;
  tnm_state_e state_q;
  logic [STAT_W-1:0] clr_mask0_q;
  logic [STAT_W-1:0] clr_mask1_q;
  logic [15:0] shift_q;
  logic [4:0] bit_cnt_q;
  logic cmd_data_q;
  logic ack_q;
  logic nack_q;
  logic irq_hold_q;
  logic [STAT_W-1:0] st0_d;
  logic [STAT_W-1:0] st1_d;
  logic accept;
  logic illegal;
  logic is_phys;
  logic clr_now;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Commands arriving while a modem handshake is running are dropped; host must wait for FF.
  assign accept = clk_en && cmd_valid && (state_q == TNM_IDLE);
  assign illegal = (command_register[7:5] == 3'b000);
  assign is_phys = (command_register[7:3] == PHYS_UPPER) && (command_register[2:0] != 3'b000);
  assign clr_now = (state_q == TNM_CLR_EXEC);

  // ----------------------------------------------------------------
  // Receive-test pattern word
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pattern_timing_word <= PATTERN_RESET;
      rx_test_frame_len_q <= '0;
      rx_test_preamble_cnt_q <= '0;
      rx_test_preamble_octet_q <= '0;
    end else if (clk_en && pattern_timing_wr) begin
      pattern_timing_word <= pattern_timing_wdata;
      rx_test_frame_len_q <= {1'b0, pattern_timing_wdata[15:PT_LEN_LSB]} + FRAME_LEN_ADJ;
      rx_test_preamble_cnt_q <= {1'b0, pattern_timing_wdata[10:PT_PRE_LSB]} + PRE_CNT_ADJ;
      rx_test_preamble_octet_q <= pattern_timing_wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Self-test mode and receive status
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      test_mode_q <= TNM_TEST_NONE;
    end else if (accept) begin
      unique case (command_register)
        CMD_HOST_IF_TEST: test_mode_q <= TNM_TEST_HOST;
        CMD_FDX_LOOP_TEST: test_mode_q <= TNM_TEST_FDX;
        CMD_TX_TEST_A, CMD_TX_TEST_B: test_mode_q <= TNM_TEST_TX;
        CMD_RX_TEST: test_mode_q <= TNM_TEST_RX;
        CMD_OFFLINE: test_mode_q <= TNM_TEST_NONE;
        default: test_mode_q <= test_mode_q;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fd_status_we_q <= 1'b0;
      fd_status_q <= '0;
    end else if (clk_en) begin
      fd_status_we_q <= rx_frame_done && (test_mode_q == TNM_TEST_RX);
      if (rx_frame_done) fd_status_q <= rx_frame_status;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_ptr_valid_q <= 1'b0;
    end else if (accept && command_register == CMD_RESP_READY && !predefined_resp_mode) begin
      resp_ptr_valid_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status words and request
  // ----------------------------------------------------------------
  always_comb begin
    st0_d = int_status0_q;
    st1_d = int_status1_q;
    if (clr_now) begin
      st0_d = st0_d & ~clr_mask0_q;
      st1_d = st1_d & ~clr_mask1_q;
    end
    // New events win over a clear in the same cycle
    st0_d = st0_d | status_set0;
    st1_d = st1_d | status_set1;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_status0_q <= '0;
      int_status1_q <= '0;
      clr_mask0_q <= '0;
      clr_mask1_q <= '0;
    end else if (clk_en) begin
      int_status0_q <= st0_d;
      int_status1_q <= st1_d;
      if (accept && command_register == CMD_INT_CLEAR) begin
        clr_mask0_q <= cmd_param_word0[STAT_W-1:0];
        clr_mask1_q <= cmd_param_word1[STAT_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_hold_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else if (clk_en) begin
      if (accept && command_register == CMD_INT_CLEAR) begin
        irq_hold_q <= 1'b1;
        irq_n_q <= 1'b1;
      end else begin
        if (clr_now) irq_hold_q <= 1'b0;
        irq_n_q <= ~(!irq_hold_q && (|(int_status0_q & status_mask0) || |(int_status1_q & status_mask1)));
      end
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer and station management
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= TNM_IDLE;
      semaphore_q <= SEM_DONE;
      cmd_result_word <= '0;
      cmd_return_word_q <= SMD_DATA_RESET;
      shift_q <= '0;
      bit_cnt_q <= '0;
      cmd_data_q <= 1'b0;
      ack_q <= 1'b0;
      nack_q <= 1'b0;
      station_mgmt_request_n <= 1'b1;
      tx_symbol_line_0 <= 1'b1;
      tx_symbol_line_1 <= 1'b0;
      tx_symbol_line_2 <= 1'b0;
    end else if (clk_en) begin
      unique case (state_q)
        TNM_IDLE: begin
          if (accept) begin
            semaphore_q <= SEM_BUSY;
            if (illegal) begin
              semaphore_q <= SEM_ILLEGAL;
            end else if (command_register == CMD_INT_CLEAR) begin
              state_q <= TNM_CLR_EXEC;
            end else if (command_register == CMD_END_PHYS) begin
              station_mgmt_request_n <= 1'b1;
              state_q <= TNM_SM_WAIT_END;
            end else if (is_phys) begin
              station_mgmt_request_n <= 1'b0;
              tx_symbol_line_0 <= 1'b1;
              tx_symbol_line_2 <= command_register[1];
              tx_symbol_line_1 <= command_register[0];
              cmd_data_q <= command_register[PHYS_DATA_BIT];
              shift_q <= cmd_param_word0;
              ack_q <= 1'b0;
              nack_q <= 1'b0;
              state_q <= TNM_SM_WAIT_ACK;
            end else begin
              cmd_result_word <= 8'h01 << RES_CONF_BIT;
              semaphore_q <= SEM_DONE;
            end
          end
        end
        TNM_CLR_EXEC: begin
          semaphore_q <= SEM_DONE;
          state_q <= TNM_IDLE;
        end
        TNM_SM_WAIT_ACK: begin
          if (!station_mgmt_indication_n && (rx_symbol_line_1 || rx_symbol_line_2)) begin
            ack_q <= rx_symbol_line_1;
            nack_q <= rx_symbol_line_2;
            if (cmd_data_q) begin
              bit_cnt_q <= '0;
              state_q <= TNM_SM_SHIFT_OUT;
            end else begin
              tx_symbol_line_1 <= 1'b0;
              tx_symbol_line_2 <= 1'b0;
              state_q <= TNM_SM_WAIT_IDLE;
            end
          end
        end
        TNM_SM_SHIFT_OUT: begin
          tx_symbol_line_0 <= shift_q[0];
          shift_q <= {1'b0, shift_q[15:1]};
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == SMD_BITS - 5'h01) begin
            state_q <= TNM_SM_WAIT_START;
          end
        end
        TNM_SM_WAIT_START: begin
          tx_symbol_line_0 <= 1'b1;
          if (!rx_symbol_line_0) begin
            bit_cnt_q <= '0;
            state_q <= TNM_SM_SHIFT_IN;
          end
        end
        TNM_SM_SHIFT_IN: begin
          shift_q <= {rx_symbol_line_0, shift_q[15:1]};
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == SMD_BITS - 5'h01) begin
            tx_symbol_line_1 <= 1'b0;
            tx_symbol_line_2 <= 1'b0;
            state_q <= TNM_SM_WAIT_IDLE;
          end
        end
        TNM_SM_WAIT_IDLE: begin
          if (!station_mgmt_indication_n && !rx_symbol_line_1 && !rx_symbol_line_2) begin
            if (cmd_data_q) cmd_return_word_q <= shift_q;
            cmd_result_word <= 8'((ack_q << RES_ACK_BIT) | (nack_q << RES_NACK_BIT) | 8'h01);
            semaphore_q <= SEM_DONE;
            state_q <= TNM_IDLE;
          end
        end
        TNM_SM_WAIT_END: begin
          if (station_mgmt_indication_n) begin
            cmd_result_word <= 8'h01 << RES_CONF_BIT;
            semaphore_q <= SEM_DONE;
            state_q <= TNM_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ILLEGAL_FE: assert property (@(posedge core_clk) disable iff (!rst_b)
    accept && illegal |=> semaphore_q == SEM_ILLEGAL && state_q == TNM_IDLE) else $error("illegal command not FE");
  AST_IRQ_DROP: assert property (@(posedge core_clk) disable iff (!rst_b)
    accept && command_register == CMD_INT_CLEAR |=> irq_n_q) else $error("irq not negated on clear");
  AST_CLEAR_MASK: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && clr_now && status_set0 == '0 |=> (int_status0_q & $past(clr_mask0_q)) == '0)
    else $error("masked bit survived clear");
  AST_NO_TCC: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && clr_now && !status_set0[IST0_CMD_COMPLETE_BIT] && !int_status0_q[IST0_CMD_COMPLETE_BIT]
    |=> !int_status0_q[IST0_CMD_COMPLETE_BIT]) else $error("complete flag set by clear");
  AST_STATION_MGMT_REQUEST_N_LOW: assert property (@(posedge core_clk) disable iff (!rst_b)
    accept && is_phys |=> !station_mgmt_request_n ##0 tx_symbol_line_0) else $error("request not low");
  AST_END_WAIT: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_q == TNM_SM_WAIT_END && station_mgmt_request_n && !station_mgmt_indication_n |=> state_q == TNM_SM_WAIT_END)
    else $error("end done before indication");
  AST_RX_LEN: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && pattern_timing_wr |=> rx_test_frame_len_q == {1'b0, $past(pattern_timing_wdata[15:11])} + 6'h02)
    else $error("frame length wrong");
  AST_RX_FD: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && rx_frame_done && test_mode_q == TNM_TEST_RX |=> fd_status_we_q) else $error("fd status missing");
  AST_RESP: assert property (@(posedge core_clk) disable iff (!rst_b)
    accept && command_register == CMD_RESP_READY && predefined_resp_mode && !resp_ptr_valid_q |=> !resp_ptr_valid_q)
    else $error("response ready in predefined mode");
  COV_PHYS: cover property (@(posedge core_clk) state_q == TNM_SM_WAIT_IDLE ##1 state_q == TNM_IDLE);
  COV_DATA: cover property (@(posedge core_clk) state_q == TNM_SM_SHIFT_IN);
  COV_CLR: cover property (@(posedge core_clk) clr_now);
  COV_RXT: cover property (@(posedge core_clk) fd_status_we_q);
endmodule : tnm_cmd_interp

//--- test/tnm_modem_model.sv
// Behavioural modem on the station-management side of the command interpreter.
// Assumes symbol lines synchronous to core_clk; the bench picks delay and ack or nack.
`timescale 1ns/1ps
module tnm_modem_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic station_mgmt_request_n,
  input wire logic tx_symbol_line_0,
  input wire logic tx_symbol_line_1,
  input wire logic tx_symbol_line_2,
  input wire logic ack_sel,
  input wire logic [3:0] resp_dly,
  input wire logic data_sel,
  input wire logic [15:0] ret_word,
  output logic [15:0] got_word,
  output logic station_mgmt_indication_n,
  output logic rx_symbol_line_0,
  output logic rx_symbol_line_1,
  output logic rx_symbol_line_2
);
  logic [3:0] cnt_q;
  logic cmd_seen;
  logic [2:0] tgt;
  logic [5:0] dc_q;
  logic ans_on;
  // Line 0 carries serial data during a data command, so it does not gate the code
  assign cmd_seen = !station_mgmt_request_n && (tx_symbol_line_1 || tx_symbol_line_2);
  assign tgt = {station_mgmt_request_n, cmd_seen && ack_sel, cmd_seen && !ack_sel};
  assign ans_on = !station_mgmt_indication_n && (rx_symbol_line_1 || rx_symbol_line_2);
  // Serial exchange is timed from the first cycle the answer stands, as the interpreter counts it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dc_q <= 6'h00;
      got_word <= 16'h0000;
      rx_symbol_line_0 <= 1'h1;
    end else if (!ans_on || !data_sel) begin
      dc_q <= 6'h00;
      rx_symbol_line_0 <= 1'h1;
    end else if (dc_q != 6'h24) begin
      dc_q <= dc_q + 6'h01;
      if (dc_q >= 6'h02 && dc_q <= 6'h11) got_word <= {tx_symbol_line_0, got_word[15:1]};
      if (dc_q == 6'h12) rx_symbol_line_0 <= 1'h0;
      else if (dc_q >= 6'h13 && dc_q <= 6'h22) rx_symbol_line_0 <= ret_word[4'(dc_q - 6'h13)];
      else rx_symbol_line_0 <= 1'h1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {station_mgmt_indication_n, rx_symbol_line_1, rx_symbol_line_2} <= 3'h4;
      cnt_q <= 4'h0;
    end else if ({station_mgmt_indication_n, rx_symbol_line_1, rx_symbol_line_2} === tgt) begin
      cnt_q <= 4'h0;
    end else if (cnt_q < resp_dly) begin
      cnt_q <= cnt_q + 4'h1;
    end else begin
      // Every answer comes resp_dly+1 cycles after its target changes, so slow modems are modelled too
      {station_mgmt_indication_n, rx_symbol_line_1, rx_symbol_line_2} <= tgt;
      cnt_q <= 4'h0;
    end
  end
endmodule : tnm_modem_model

//--- test/tb_top.sv
// Self-checking bench for the command interpreter with a behavioural modem.
// Assumes the package constants; inputs change on the falling clock edge.
`timescale 1ns/1ps
module tb_top;
  import tnm_pkg::*;
  logic core_clk = 1'h0, rst_b = 1'h0, clk_en = 1'h1, cmd_valid = 1'h0, pattern_timing_wr = 1'h0;
  logic predefined_resp_mode = 1'h1, rx_frame_done = 1'h0, ack_sel = 1'h1, data_sel = 1'h0;
  logic [15:0] ret_word = 16'h0000, got_word;
  logic [7:0] command_register = 8'h00;
  logic [15:0] cmd_param_word0 = 16'h0000, cmd_param_word1 = 16'h0000, pattern_timing_wdata = 16'h0000;
  logic [15:0] status_set0 = 16'h0000, status_set1 = 16'h0000, rx_frame_status = 16'h0000;
  logic [15:0] status_mask0 = 16'h0000, status_mask1 = 16'h0000;
  logic [3:0] resp_dly = 4'h3;
  logic ind_n, rx0, rx1, rx2, irq_n_q, fd_status_we_q, resp_ptr_valid_q, station_mgmt_request_n, tx0, tx1, tx2;
  logic [7:0] semaphore_q, rx_test_preamble_octet_q, cmd_result_word;
  logic [15:0] pattern_timing_word, int_status0_q, int_status1_q, cmd_return_word_q, fd_status_q;
  logic [5:0] rx_test_frame_len_q;
  logic [3:0] rx_test_preamble_cnt_q;
  logic [2:0] test_mode_q;
  logic [7:0] tcode [5] = '{CMD_HOST_IF_TEST, CMD_FDX_LOOP_TEST, CMD_RX_TEST, CMD_TX_TEST_A, CMD_TX_TEST_B};
  logic [2:0] tmode [5] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h3};
  int err_count = 0;
  int comparisons = 0;
  always #2 core_clk = ~core_clk;
  tnm_cmd_interp i_tnm_cmd_interp (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .cmd_valid(cmd_valid),
    .command_register(command_register), .cmd_param_word0(cmd_param_word0), .cmd_param_word1(cmd_param_word1),
    .pattern_timing_wr(pattern_timing_wr), .pattern_timing_wdata(pattern_timing_wdata),
    .predefined_resp_mode(predefined_resp_mode), .status_set0(status_set0), .status_set1(status_set1),
    .status_mask0(status_mask0), .status_mask1(status_mask1), .rx_frame_done(rx_frame_done),
    .rx_frame_status(rx_frame_status), .station_mgmt_indication_n(ind_n), .rx_symbol_line_0(rx0),
    .rx_symbol_line_1(rx1), .rx_symbol_line_2(rx2), .semaphore_q(semaphore_q),
    .pattern_timing_word(pattern_timing_word), .rx_test_frame_len_q(rx_test_frame_len_q),
    .rx_test_preamble_cnt_q(rx_test_preamble_cnt_q), .rx_test_preamble_octet_q(rx_test_preamble_octet_q),
    .test_mode_q(test_mode_q), .int_status0_q(int_status0_q), .int_status1_q(int_status1_q), .irq_n_q(irq_n_q),
    .cmd_result_word(cmd_result_word), .cmd_return_word_q(cmd_return_word_q), .fd_status_we_q(fd_status_we_q),
    .fd_status_q(fd_status_q), .resp_ptr_valid_q(resp_ptr_valid_q), .station_mgmt_request_n(station_mgmt_request_n),
    .tx_symbol_line_0(tx0), .tx_symbol_line_1(tx1), .tx_symbol_line_2(tx2));
  tnm_modem_model i_tnm_modem_model (.core_clk(core_clk), .rst_b(rst_b), .station_mgmt_request_n(station_mgmt_request_n),
    .tx_symbol_line_0(tx0), .tx_symbol_line_1(tx1), .tx_symbol_line_2(tx2), .ack_sel(ack_sel), .resp_dly(resp_dly),
    .data_sel(data_sel), .ret_word(ret_word), .got_word(got_word),
    .station_mgmt_indication_n(ind_n), .rx_symbol_line_0(rx0), .rx_symbol_line_1(rx1), .rx_symbol_line_2(rx2));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic issue(input logic [7:0] code, input logic [15:0] p0);
    @(negedge core_clk);
    command_register = code;
    cmd_param_word0 = p0;
    cmd_param_word1 = ~p0;
    cmd_valid = 1'h1;
    @(negedge core_clk);
    cmd_valid = 1'h0;
  endtask : issue
  task automatic wait_done();
    int n;
    n = 0;
    @(negedge core_clk);
    while (semaphore_q === SEM_BUSY && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 500) chk(16'(semaphore_q), 16'(SEM_DONE));
  endtask : wait_done
  task automatic pulse(ref logic [15:0] sig, input logic [15:0] v);
    @(negedge core_clk);
    sig = v;
    @(negedge core_clk);
    sig = 16'h0000;
    @(negedge core_clk);
  endtask : pulse
  // Interrupt request expected from stored status and enable masks
  function automatic logic [15:0] exp_irq_n(input logic [15:0] s0, input logic [15:0] s1);
    return 16'(!(|((s0 & status_mask0) | (s1 & status_mask1))));
  endfunction : exp_irq_n
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] s0, s1, mk, w;
    logic [7:0] p;
    s0 = 16'h0000;
    s1 = 16'h0000;
    void'($urandom(32'h67ffe5e6));
    repeat (5) @(negedge core_clk);
    rst_b = 1'h1;
    chk(16'({semaphore_q, irq_n_q, station_mgmt_request_n, tx0}), 16'h07FF);
    for (int i = 0; i < 4; i++) begin
      status_mask0 = 16'($urandom);
      status_mask1 = 16'($urandom);
      w = 16'($urandom);
      s1 |= ~w;
      pulse(status_set1, ~w);
      s0 |= w;
      pulse(status_set0, w);
      chk(irq_n_q, exp_irq_n(s0, s1));
      mk = (i == 0) ? 16'hFFFF : 16'($urandom);
      issue(CMD_INT_CLEAR, mk);
      @(negedge core_clk);
      chk(16'(irq_n_q), 16'h0001);
      wait_done();
      s0 &= ~mk;
      s1 &= mk;
      repeat (2) @(negedge core_clk);
      chk(int_status0_q, s0);
      chk(int_status1_q, s1);
      chk(irq_n_q, exp_irq_n(s0, s1));
    end
    for (int i = 0; i < 5; i++) begin
      w = 16'($urandom);
      if (tcode[i] == CMD_RX_TEST) begin
        pattern_timing_wdata = w;
        pattern_timing_wr = 1'h1;
        @(negedge core_clk);
        pattern_timing_wr = 1'h0;
      end
      p = 8'($urandom);
      issue(tcode[i], {p, p});
      wait_done();
      chk(16'(test_mode_q), 16'(tmode[i]));
      if (tcode[i] == CMD_RX_TEST) begin
        chk(pattern_timing_word, w);
        chk(16'(rx_test_frame_len_q), 16'(w[15:11]) + 16'h0002);
        chk(16'({rx_test_preamble_cnt_q, rx_test_preamble_octet_q}), 16'({{1'b0, w[10:8]} + 4'h1, w[7:0]}));
        rx_frame_status = 16'($urandom);
        rx_frame_done = 1'h1;
        @(negedge core_clk);
        rx_frame_done = 1'h0;
        chk(16'(fd_status_we_q), 16'h0001);
        chk(fd_status_q, rx_frame_status);
        issue(CMD_RESP_READY, 16'h0000);
        wait_done();
        chk(16'({resp_ptr_valid_q, test_mode_q}), 16'h0004);
        s0 |= 16'h0006;
        pulse(status_set0, 16'h0006);
        // A write and a status event while clk_en is low must both be lost
        clk_en = 1'h0;
        pattern_timing_wdata = ~w;
        pattern_timing_wr = 1'h1;
        status_set0 = 16'hFFFF;
        @(negedge core_clk);
        pattern_timing_wr = 1'h0;
        status_set0 = 16'h0000;
        clk_en = 1'h1;
        chk(pattern_timing_word, w);
        chk(int_status0_q, s0);
      end
      issue(CMD_OFFLINE, 16'h0000);
      wait_done();
      chk(16'({cmd_result_word[0], test_mode_q}), 16'h0008);
    end
    p = {3'h0, 5'($urandom)} | 8'h02;
    issue(p, 16'h0000);
    wait_done();
    chk(16'({semaphore_q, test_mode_q}), 16'({SEM_ILLEGAL, 3'h0}));
    for (int i = 1; i < 8; i++) begin
      // A4 puts no code on lines 1 and 2, which the modem cannot tell from idle
      if (i == 4) continue;
      ack_sel = 1'($urandom);
      resp_dly = 4'(3 + $urandom_range(4));
      data_sel = 1'(i >> 2);
      w = 16'($urandom);
      ret_word = 16'($urandom);
      issue(8'hA0 | 8'(i), w);
      @(negedge core_clk);
      chk(16'({station_mgmt_request_n, tx2, tx1, tx0}), 16'({1'h0, 2'(i), 1'h1}));
      wait_done();
      chk(16'(cmd_result_word[2:0]), ack_sel ? 16'h0005 : 16'h0003);
      chk(16'({station_mgmt_request_n, tx2, tx1, tx0}), 16'h0001);
      if (data_sel) begin
        chk(got_word, w);
        chk(cmd_return_word_q, ret_word);
      end
    end
    resp_dly = 4'($urandom_range(7));
    issue(CMD_END_PHYS, 16'h0000);
    @(negedge core_clk);
    chk(16'(station_mgmt_request_n), 16'h0001);
    wait_done();
    chk(16'({cmd_result_word[0], ind_n}), 16'h0003);
    predefined_resp_mode = 1'h0;
    issue(CMD_RESP_READY, 16'h0000);
    wait_done();
    chk(16'(resp_ptr_valid_q), 16'h0001);
    close_out();
  end
  initial begin
    #40000;
    err_count++;
    close_out();
  end
endmodule : tb_top
